// *** hdl/mtd_pkg.sv ***
// Purpose: shared constants and types of the multi-touch decoder
// Assumes: 50 MHz reference clock, touch controller on a 100 kHz serial bus
// Notes:   report byte layout and bus address are local conventions
package mtd_pkg;

  // clock and serial bus timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // touch controller access
  localparam logic [6:0] TOUCH_ADDR      = 7'h38;
  localparam logic [7:0] TOUCH_FIRST_REG = 8'h00;

  // report layout, one byte per slot, read in this order
  localparam int RPT_BYTES    = 10;
  localparam int RB_GESTURE   = 0;
  localparam int RB_COUNT     = 1;
  localparam int RB_X1_HI     = 2;
  localparam int RB_X1_LO     = 3;
  localparam int RB_Y1_HI     = 4;
  localparam int RB_Y1_LO     = 5;
  localparam int RB_X2_HI     = 6;
  localparam int RB_X2_LO     = 7;
  localparam int RB_Y2_HI     = 8;
  localparam int RB_Y2_LO     = 9;

  // result widths
  localparam int X_W     = 10;
  localparam int Y_W     = 9;
  localparam int COUNT_W = 2;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 2'h2;

  // gesture identifiers, passed through unchanged
  localparam logic [7:0] G1_NORTH       = 8'h10;
  localparam logic [7:0] G1_NORTH_WEST  = 8'h1e;
  localparam logic [7:0] G1_CLICK       = 8'h20;
  localparam logic [7:0] G1_DBL_CLICK   = 8'h22;
  localparam logic [7:0] G1_ROTATE_CW   = 8'h28;
  localparam logic [7:0] G1_ROTATE_CCW  = 8'h29;
  localparam logic [7:0] G2_NORTH       = 8'h30;
  localparam logic [7:0] G2_NORTH_WEST  = 8'h3e;
  localparam logic [7:0] G2_CLICK       = 8'h40;
  localparam logic [7:0] G2_ZOOM_IN     = 8'h48;
  localparam logic [7:0] G2_ZOOM_OUT    = 8'h49;

  // sequence steps
  localparam logic [3:0] STEP_RD_FIRST = 4'h5;
  localparam logic [3:0] STEP_STOP     = 4'hf;

  typedef enum logic [1:0] {
    MTD_CMD_START = 2'h0,
    MTD_CMD_STOP  = 2'h1,
    MTD_CMD_WRITE = 2'h2,
    MTD_CMD_READ  = 2'h3
  } mtd_cmd_t;

endpackage

// *** hdl/mtd_byte_if.sv ***
// Purpose: byte-level command channel between sequencer and bus engine
// Assumes: one command outstanding at a time
// Notes:   done is a one-cycle pulse ending each command
`timescale 1ns/1ps
interface mtd_byte_if;
  import mtd_pkg::*;
  mtd_cmd_t   cmd;
  logic       cmd_valid;
  logic [7:0] wdata;
  logic       rd_ack;
  logic       done;
  logic [7:0] rdata;
  logic       nack;

  modport ctrl   (output cmd, cmd_valid, wdata, rd_ack, input done, rdata, nack);
  modport engine (input cmd, cmd_valid, wdata, rd_ack, output done, rdata, nack);
endinterface

// *** hdl/mtd_i2c_engine.sv ***
// Purpose: serial bus master executing start, stop, byte write and byte read
// Assumes: single master, no clock stretching by the target
// Notes:   each bit takes four quarter periods of QTR_CYC clocks
`timescale 1ns/1ps
module mtd_i2c_engine
  import mtd_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // clock and reset
  input  wire logic      clk_sys_i,
  input  wire logic      nrst_i,
  // command channel
  mtd_byte_if.engine     bus,
  // serial pins
  output logic           scl_o,
  input  wire logic      sda_i,
  output logic           sda_oe_o
);
  import mtd_pkg::*;

  localparam int DW = $clog2(QTR + 1);
  localparam logic [DW-1:0] DIV_LOAD = DW'(QTR - 1);

  typedef enum logic [1:0] {
    MTD_E_IDLE  = 2'b00,
    MTD_E_START = 2'b01,
    MTD_E_BITS  = 2'b11,
    MTD_E_STOP  = 2'b10
  } mtd_estate_t;

  mtd_estate_t      state_reg, state_next;
  logic [DW-1:0]    div_reg,   div_next;
  logic [1:0]       q_reg,     q_next;
  logic [3:0]       bit_reg,   bit_next;
  logic [7:0]       sh_reg,    sh_next;
  logic             rd_reg,    rd_next;
  logic             ack_reg,   ack_next;
  logic             scl_reg,   scl_next;
  logic             low_reg,   low_next;
  logic             nack_reg,  nack_next;
  logic             done_reg,  done_next;
  logic             sda_s1, sda_s2;
  logic             tick;

  assign tick      = (div_reg == '0);
  assign scl_o     = scl_reg;
  assign sda_oe_o  = low_reg;         // open drain: only ever pulls low
  assign bus.done  = done_reg;
  assign bus.rdata = sh_reg;
  assign bus.nack  = nack_reg;

  always_comb begin
    state_next = state_reg;
    div_next   = (tick || state_reg == MTD_E_IDLE) ? DIV_LOAD : div_reg - DW'(1);
    q_next     = q_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    rd_next    = rd_reg;
    ack_next   = ack_reg;
    scl_next   = scl_reg;
    low_next   = low_reg;
    nack_next  = nack_reg;
    done_next  = 1'b0;
    case (state_reg)
      MTD_E_IDLE: begin
        if (bus.cmd_valid) begin
          q_next   = 2'h0;
          bit_next = 4'h0;
          sh_next  = bus.wdata;
          rd_next  = (bus.cmd == MTD_CMD_READ);
          ack_next = bus.rd_ack;
          case (bus.cmd)
            MTD_CMD_START: state_next = MTD_E_START;
            MTD_CMD_STOP:  state_next = MTD_E_STOP;
            default:       state_next = MTD_E_BITS;
          endcase
        end
      end
      MTD_E_START: begin
        if (tick) begin
          q_next = q_reg + 2'h1;
          case (q_reg)
            2'h0: begin
              scl_next = 1'b0;
              low_next = 1'b0;
            end
            2'h1: scl_next = 1'b1;
            2'h2: low_next = 1'b1;      // data falls while clock high
            default: begin
              scl_next   = 1'b0;
              done_next  = 1'b1;
              state_next = MTD_E_IDLE;
            end
          endcase
        end
      end
      MTD_E_STOP: begin
        if (tick) begin
          q_next = q_reg + 2'h1;
          case (q_reg)
            2'h0: begin
              scl_next = 1'b0;
              low_next = 1'b1;
            end
            2'h1: scl_next = 1'b1;
            2'h2: low_next = 1'b0;      // data rises while clock high
            default: begin
              done_next  = 1'b1;
              state_next = MTD_E_IDLE;
            end
          endcase
        end
      end
      MTD_E_BITS: begin
        if (tick) begin
          q_next = q_reg + 2'h1;
          case (q_reg)
            2'h0: begin
              scl_next = 1'b0;
              if (bit_reg == 4'h8) begin
                low_next = rd_reg & ack_reg;
              end else begin
                low_next = ~rd_reg & ~sh_reg[7];
              end
            end
            2'h1: scl_next = 1'b1;
            2'h2: begin
              // shifting in on writes too keeps one path for both directions
              if (bit_reg == 4'h8) begin
                nack_next = ~rd_reg & sda_s2;
              end else begin
                sh_next = {sh_reg[6:0], sda_s2};
              end
            end
            default: begin
              scl_next = 1'b0;
              if (bit_reg == 4'h8) begin
                done_next  = 1'b1;
                state_next = MTD_E_IDLE;
              end else begin
                bit_next = bit_reg + 4'h1;
              end
            end
          endcase
        end
      end
      default: state_next = MTD_E_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= MTD_E_IDLE;
      div_reg   <= '0;
      q_reg     <= 2'h0;
      bit_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      rd_reg    <= 1'b0;
      ack_reg   <= 1'b0;
      scl_reg   <= 1'b1;
      low_reg   <= 1'b0;
      nack_reg  <= 1'b0;
      done_reg  <= 1'b0;
      sda_s1    <= 1'b1;
      sda_s2    <= 1'b1;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      q_reg     <= q_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      rd_reg    <= rd_next;
      ack_reg   <= ack_next;
      scl_reg   <= scl_next;
      low_reg   <= low_next;
      nack_reg  <= nack_next;
      done_reg  <= done_next;
      sda_s1    <= sda_i;
      sda_s2    <= sda_s1;
    end
  end

endmodule // mtd_i2c_engine

// *** hdl/mtd_touch_decoder.sv ***
// Purpose: reads touch reports from the controller and presents decoded results
// Assumes: controller raises its active-low interrupt when a report is waiting
// Notes:   a failed address phase drops the event without a report
//
// Summary of operation
// - single reference clock; block held in reset while active-low reset is low.
// - block is bus master; drives serial clock, data line is two-way.
// - rising report pulse means all six result outputs hold valid values.
// - first contact horizontal position is a 10-bit unsigned output.
// - first contact vertical position is a 9-bit unsigned output.
// - second contact position on separate outputs, 10 and 9 bits wide.
// - contact count on 2 bits; only zero, one, two; never three.
// - gesture identifier on an 8-bit output, valid with the report pulse.
// - gesture codes are the defined one-point and two-point identifiers; the block passes any other byte through unchanged.
`timescale 1ns/1ps
module mtd_touch_decoder
  import mtd_pkg::*;
#(
  parameter int         QTR        = QTR_CYC,
  parameter logic [6:0] DEV_ADDR   = TOUCH_ADDR,
  parameter logic [7:0] FIRST_REG  = TOUCH_FIRST_REG
) (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                nrst_i,
  // touch controller
  input  wire logic                touch_irq_in_n_i,
  output logic                     touch_scl_o,
  input  wire logic                touch_sda_io_i,
  output logic                     touch_sda_io_o,
  output logic                     touch_sda_io_oe_o,
  // decoded results
  output logic                     report_valid_pulse_o,
  output logic [mtd_pkg::X_W-1:0]  point1_x_o,
  output logic [mtd_pkg::Y_W-1:0]  point1_y_o,
  output logic [mtd_pkg::X_W-1:0]  point2_x_o,
  output logic [mtd_pkg::Y_W-1:0]  point2_y_o,
  output logic [mtd_pkg::COUNT_W-1:0] contact_count_o,
  output logic [7:0]               gesture_code_o
);
  import mtd_pkg::*;

  typedef enum logic [1:0] {
    MTD_M_IDLE    = 2'b00,
    MTD_M_ISSUE   = 2'b01,
    MTD_M_WAIT    = 2'b11,
    MTD_M_PUBLISH = 2'b10
  } mtd_mstate_t;

  mtd_byte_if link ();

  mtd_mstate_t          state_reg, state_next;
  logic [3:0]           step_reg,  step_next;
  logic                 pend_reg,  pend_next;
  logic                 err_reg,   err_next;
  logic [7:0]           rpt_reg [RPT_BYTES];
  logic [7:0]           rpt_next [RPT_BYTES];
  logic [X_W-1:0]       x1_reg, x1_next, x2_reg, x2_next;
  logic [Y_W-1:0]       y1_reg, y1_next, y2_reg, y2_next;
  logic [COUNT_W-1:0]   cnt_reg, cnt_next;
  logic [7:0]           gest_reg, gest_next;
  logic                 pulse_reg, pulse_next;
  logic                 irq_s1, irq_s2, irq_s3;
  logic                 irq_fall;

  // bus engine, open-drain data: output value is always low
  mtd_i2c_engine #(
    .QTR      (QTR)
  ) u_engine (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .bus       (link.engine),
    .scl_o     (touch_scl_o),
    .sda_i     (touch_sda_io_i),
    .sda_oe_o  (touch_sda_io_oe_o)
  );
  assign touch_sda_io_o = 1'b0;

  // controller pulls its interrupt low when data waits; two stages
  // synchronise the pin, the third only remembers the last level, so
  // a fall is acted on three clocks after it reaches the pin
  assign irq_fall = irq_s3 & ~irq_s2;

  // command for each step of the read sequence
  // steps: start, address write, register, repeated start, address read,
  // ten reads, stop; a refused write skips straight to the stop
  always_comb begin
    link.wdata  = 8'h00;
    link.rd_ack = 1'b1;
    case (step_reg)
      4'h0, 4'h3: link.cmd = MTD_CMD_START;
      4'h1: begin
        link.cmd   = MTD_CMD_WRITE;
        link.wdata = {DEV_ADDR, 1'b0};
      end
      4'h2: begin
        link.cmd   = MTD_CMD_WRITE;
        link.wdata = FIRST_REG;
      end
      4'h4: begin
        link.cmd   = MTD_CMD_WRITE;
        link.wdata = {DEV_ADDR, 1'b1};
      end
      STEP_STOP: link.cmd = MTD_CMD_STOP;
      default: begin
        link.cmd    = MTD_CMD_READ;
        // last byte is refused so the controller releases the line
        link.rd_ack = (step_reg != STEP_STOP - 4'h1);
      end
    endcase
  end
  assign link.cmd_valid = (state_reg == MTD_M_ISSUE);

  always_comb begin
    state_next = state_reg;
    step_next  = step_reg;
    pend_next  = pend_reg | irq_fall;   // an edge during a clear is kept
    err_next   = err_reg;
    rpt_next   = rpt_reg;
    x1_next    = x1_reg;
    y1_next    = y1_reg;
    x2_next    = x2_reg;
    y2_next    = y2_reg;
    cnt_next   = cnt_reg;
    gest_next  = gest_reg;
    pulse_next = 1'b0;
    case (state_reg)
      MTD_M_IDLE: begin
        // one pending flag: several interrupts during a read merge into one
        if (pend_reg) begin
          pend_next  = irq_fall;
          step_next  = 4'h0;
          err_next   = 1'b0;
          state_next = MTD_M_ISSUE;
        end
      end
      MTD_M_ISSUE: state_next = MTD_M_WAIT;
      MTD_M_WAIT: begin
        if (link.done) begin
          // bytes only fill the buffer; visible results move at publish
          if (step_reg >= STEP_RD_FIRST && step_reg < STEP_STOP) begin
            rpt_next[step_reg - STEP_RD_FIRST] = link.rdata;
          end
          if (step_reg == STEP_STOP) begin
            state_next = err_reg ? MTD_M_IDLE : MTD_M_PUBLISH;
          end else if (link.cmd == MTD_CMD_WRITE && link.nack) begin
            err_next   = 1'b1;
            step_next  = STEP_STOP;
            state_next = MTD_M_ISSUE;
          end else begin
            step_next  = step_reg + 4'h1;
            state_next = MTD_M_ISSUE;
          end
        end
      end
      MTD_M_PUBLISH: begin
        // all results change together with the pulse and only here
        // high byte bits above the coordinate width are ignored
        x1_next = {rpt_reg[RB_X1_HI][1:0], rpt_reg[RB_X1_LO]};
        y1_next = {rpt_reg[RB_Y1_HI][0], rpt_reg[RB_Y1_LO]};
        x2_next = {rpt_reg[RB_X2_HI][1:0], rpt_reg[RB_X2_LO]};
        y2_next = {rpt_reg[RB_Y2_HI][0], rpt_reg[RB_Y2_LO]};
        // more contacts than supported are reported as the maximum
        cnt_next = (rpt_reg[RB_COUNT] > 8'(COUNT_MAX)) ? COUNT_MAX
                 : rpt_reg[RB_COUNT][COUNT_W-1:0];
        gest_next  = rpt_reg[RB_GESTURE];
        pulse_next = 1'b1;
        state_next = MTD_M_IDLE;
      end
      default: state_next = MTD_M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= MTD_M_IDLE;
      step_reg  <= 4'h0;
      pend_reg  <= 1'b0;
      err_reg   <= 1'b0;
      for (int i = 0; i < RPT_BYTES; i++) begin
        rpt_reg[i] <= 8'h00;
      end
      x1_reg    <= '0;
      y1_reg    <= '0;
      x2_reg    <= '0;
      y2_reg    <= '0;
      cnt_reg   <= '0;
      gest_reg  <= 8'h00;
      pulse_reg <= 1'b0;
      irq_s1    <= 1'b1;
      irq_s2    <= 1'b1;
      irq_s3    <= 1'b1;
    end else begin
      state_reg <= state_next;
      step_reg  <= step_next;
      pend_reg  <= pend_next;
      err_reg   <= err_next;
      rpt_reg   <= rpt_next;
      x1_reg    <= x1_next;
      y1_reg    <= y1_next;
      x2_reg    <= x2_next;
      y2_reg    <= y2_next;
      cnt_reg   <= cnt_next;
      gest_reg  <= gest_next;
      pulse_reg <= pulse_next;
      irq_s1    <= touch_irq_in_n_i;
      irq_s2    <= irq_s1;
      irq_s3    <= irq_s2;
    end
  end

  assign report_valid_pulse_o = pulse_reg;
  assign point1_x_o           = x1_reg;
  assign point1_y_o           = y1_reg;
  assign point2_x_o           = x2_reg;
  assign point2_y_o           = y2_reg;
  assign contact_count_o      = cnt_reg;
  assign gesture_code_o       = gest_reg;

endmodule // mtd_touch_decoder

// *** verif/mtd_touch_assertions.sv ***
// Purpose: port-level temporal checks of the touch decoder
// Assumes: serial data line pulled up outside the block
// Notes:   QTR is handed on from the bound instance
`timescale 1ns/1ps
module mtd_touch_assertions
  import mtd_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // clock and reset
  input wire logic                        clk_sys_i,
  input wire logic                        nrst_i,
  // touch controller
  input wire logic                        touch_irq_in_n_i,
  input wire logic                        touch_scl_o,
  input wire logic                        touch_sda_io_i,
  input wire logic                        touch_sda_io_o,
  input wire logic                        touch_sda_io_oe_o,
  // results
  input wire logic                        report_valid_pulse_o,
  input wire logic [mtd_pkg::X_W-1:0]     point1_x_o,
  input wire logic [mtd_pkg::Y_W-1:0]     point1_y_o,
  input wire logic [mtd_pkg::X_W-1:0]     point2_x_o,
  input wire logic [mtd_pkg::Y_W-1:0]     point2_y_o,
  input wire logic [mtd_pkg::COUNT_W-1:0] contact_count_o,
  input wire logic [7:0]                  gesture_code_o
);
  // cycles the serial clock has stayed high, saturating
  logic [7:0]  hi_cnt_reg;
  logic [7:0]  hi_cnt_next;
  logic [47:0] res;

  assign res = {point1_x_o, point1_y_o, point2_x_o, point2_y_o, contact_count_o, gesture_code_o};
  always_comb begin
    hi_cnt_next = 8'h00;
    if (touch_scl_o) hi_cnt_next = (hi_cnt_reg == 8'hff) ? hi_cnt_reg : hi_cnt_reg + 8'h01;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) hi_cnt_reg <= 8'h00;
    else hi_cnt_reg <= hi_cnt_next;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence irq_when_idle;
    $fell(touch_irq_in_n_i) && hi_cnt_reg > 8'h28;
  endsequence
  sequence bus_released;
    touch_scl_o && !touch_sda_io_oe_o;
  endsequence

  pulse_one_cycle_a: assert property (
    $rose(report_valid_pulse_o) |=> !report_valid_pulse_o)
    else $error("report pulse too long");
  count_range_a: assert property (contact_count_o <= COUNT_MAX)
    else $error("contact count out of range");
  results_hold_a: assert property (!report_valid_pulse_o |-> $stable(res))
    else $error("results moved without pulse");
  sda_drive_low_a: assert property (touch_sda_io_oe_o |-> touch_sda_io_o == 1'b0)
    else $error("data line driven high");
  scl_high_min_a: assert property ($fell(touch_scl_o) |-> hi_cnt_reg >= 8'(2*QTR))
    else $error("serial clock high too short");
  irq_start_a: assert property (irq_when_idle |-> ##[3:40] !touch_scl_o)
    else $error("no transfer after interrupt");
  // pulse follows the stop by a few clocks; bound stays inside the 8-bit counter
  pulse_bus_idle_a: assert property (
    report_valid_pulse_o |-> bus_released ##0 (hi_cnt_reg < 8'(2*QTR+4)))
    else $error("pulse before stop");
  sda_moves_a: assert property (
    $changed(touch_sda_io_oe_o) && touch_scl_o |-> hi_cnt_reg >= 8'(QTR-1))
    else $error("data moved at clock edge");
endmodule // mtd_touch_assertions

bind mtd_touch_decoder mtd_touch_assertions #(.QTR(QTR)) i_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .touch_irq_in_n_i(touch_irq_in_n_i),
  .touch_scl_o(touch_scl_o), .touch_sda_io_i(touch_sda_io_i), .touch_sda_io_o(touch_sda_io_o),
  .touch_sda_io_oe_o(touch_sda_io_oe_o), .report_valid_pulse_o(report_valid_pulse_o),
  .point1_x_o(point1_x_o), .point1_y_o(point1_y_o), .point2_x_o(point2_x_o),
  .point2_y_o(point2_y_o), .contact_count_o(contact_count_o), .gesture_code_o(gesture_code_o)
);

// *** verif/mtd_touch_model.sv ***
// Purpose: behavioural touch controller on the serial bus
// Assumes: ten report bytes, open-drain line with pull-up
// Notes:   nack_i refuses the address byte
`timescale 1ns/1ps
module mtd_touch_model (
  // serial pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_oe_o,
  // report content and fault control
  input  wire logic [79:0] rpt_i,
  input  wire logic        nack_i
);
  int         bitn = 0;
  int         idx = 0;
  bit         rd = 0;
  bit         first = 0;
  bit         mack = 0;
  logic [7:0] sh = 8'h00;

  initial sda_oe_o = 1'b0;
  // start or repeated start
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      bitn = 0;
      idx = 0;
      rd = 0;
      first = 1;
    end
  end
  always @(posedge scl_i) begin
    if (bitn < 8) sh = {sh[6:0], sda_i};
    else mack = !sda_i;
    bitn = bitn + 1;
  end
  // drive only while the clock is low; a master nack ends the read
  always @(negedge scl_i) begin
    if (bitn == 8) begin
      sda_oe_o = !rd && !(first && nack_i);
    end else if (bitn == 9) begin
      if (rd) idx = idx + 1;
      rd = (rd && mack) || (first && sh[0] && !nack_i);
      first = 0;
      bitn = 0;
      sda_oe_o = rd && !rpt_i[79-8*idx];
    end else if (rd && bitn > 0) begin
      sda_oe_o = !rpt_i[79-8*idx-bitn];
    end
  end
endmodule // mtd_touch_model

// *** verif/multi_touch_decoder_test.sv ***
// Purpose: self-checking bench of the touch decoder with a controller model
// Assumes: short quarter period keeps the run brief
// Notes:   expected reports are rebuilt from the bytes the model sends
`timescale 1ns/1ps
module multi_touch_decoder_test;
  import mtd_pkg::*;

  localparam int Q = 4;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic               irq_n = 1'b1;
  logic               nack = 1'b0;
  logic [79:0]        rpt = '0;
  logic               scl;
  logic               dut_oe;
  logic               mdl_oe;
  logic               pulse;
  logic [X_W-1:0]     x1;
  logic [X_W-1:0]     x2;
  logic [Y_W-1:0]     y1;
  logic [Y_W-1:0]     y2;
  logic [COUNT_W-1:0] cnt;
  logic [7:0]         gest;
  logic [47:0]        prev_v = '0;
  logic [47:0]        exp_q[$];
  int                 n_fail = 0;
  int                 num_checks = 0;
  int                 seed = 96077;
  wire                sda = !(dut_oe || mdl_oe);
  wire [47:0]         res = {x1, y1, x2, y2, cnt, gest};
  logic [7:0]         codes[23] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e,
    8'h20, 8'h22, 8'h28, 8'h29, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3a, 8'h3c, 8'h3e,
    8'h40, 8'h48, 8'h49};

  always #5 clk_sys = ~clk_sys;

  mtd_touch_decoder #(.QTR(Q)) i_dut (
    .clk_sys_i(clk_sys), .nrst_i(nrst), .touch_irq_in_n_i(irq_n), .touch_scl_o(scl),
    .touch_sda_io_i(sda), .touch_sda_io_o(), .touch_sda_io_oe_o(dut_oe),
    .report_valid_pulse_o(pulse), .point1_x_o(x1), .point1_y_o(y1), .point2_x_o(x2),
    .point2_y_o(y2), .contact_count_o(cnt), .gesture_code_o(gest)
  );
  mtd_touch_model i_ctrl (
    .scl_i(scl), .sda_i(sda), .sda_oe_o(mdl_oe), .rpt_i(rpt), .nack_i(nack)
  );

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one controller report; refuse nacks the address, twice retriggers mid-read
  task automatic run_event(input bit refuse, input bit twice, input logic [7:0] g);
    int          n;
    int          cb;
    logic [47:0] want;
    for (int i = 0; i < 10; i++) rpt[79-8*i -: 8] = 8'($random(seed));
    rpt[79:72] = g;
    // about half the reports carry a count of 0..3 to reach the unsaturated path
    if (rpt[0]) rpt[71:64] = rpt[71:64] % 8'h04;
    nack = refuse;
    cb = int'(rpt[71:64]);
    want = {rpt[57:48], rpt[40:32], rpt[25:16], rpt[8:0], 2'(cb > 2 ? 2 : cb), g};
    if (refuse) want = prev_v;
    for (int k = 0; k <= int'(twice); k++) begin
      if (k > 0) repeat (300) @(negedge clk_sys);
      irq_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      irq_n = 1'b1;
      exp_q.push_back(want);
    end
    while (exp_q.size() > 0) begin
      n = 0;
      while (pulse !== 1'b1 && n < 4000) begin
        @(negedge clk_sys);
        n++;
      end
      check({47'h0, pulse}, {47'h0, !refuse});
      check(res, exp_q.pop_front());
      @(negedge clk_sys);
      check({47'h0, pulse}, 48'h0);
    end
    repeat (60) @(negedge clk_sys);
    check(res, want);
    prev_v = want;
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    check(res, 48'h0);
    check({46'h0, scl, dut_oe}, 48'h2);
    nrst = 1'b1;
    repeat (60) @(negedge clk_sys);
    for (int i = 0; i < 26; i++) begin
      run_event(i == 23, i == 24, i < 23 ? codes[i] : 8'($random(seed)));
    end
    give_verdict;
  end

  initial begin
    // about 2100 clocks per report, 26 reads plus one refused wait
    repeat (80000) @(posedge clk_sys);
    n_fail++;
    give_verdict;
  end
endmodule // multi_touch_decoder_test
